// >>> verilog/irq_prio_pkg.sv
package irq_prio_pkg;

  localparam int unsigned NUM_SRC = 6;
  localparam int unsigned EXT0_BIT = 0;
  localparam int unsigned TMR0_BIT = 1;
  localparam int unsigned EXT1_BIT = 2;
  localparam int unsigned TMR1_BIT = 3;
  localparam int unsigned SER0_BIT = 4;
  localparam int unsigned TMR2_BIT = 5;
  localparam logic [3:0] ADDR_PRIO = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [2:0] NO_SRC = 3'h7;

  typedef struct packed {
    logic valid;
    logic high;
    logic [2:0] id;
  } irq_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b11
  } svc_state_t;

endpackage : irq_prio_pkg

// >>> verilog/interrupt_priority_select.sv
// Behaviour
// - bit 5 gives timer two low priority at 0, high at 1
// - bit 4 gives the first serial port low priority at 0, high at 1
// - bit 3 gives timer one low priority at 0, high at 1
// - bit 2 gives external interrupt one low priority at 0, high at 1
// - bit 1 gives timer zero low priority at 0, high at 1
// - bit 0 gives external interrupt zero low priority at 0, high at 1
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module interrupt_priority_select (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [5:0] i_irq_req,
  input wire logic i_ack,
  input wire logic i_reti,
  output logic o_irq_take,
  output logic [2:0] o_irq_id,
  output logic [5:0] o_src_high
);

  logic [5:0] prio_r;
  logic [7:0] rdata_r;
  irq_prio_pkg::irq_sel_t sel_r;
  irq_prio_pkg::irq_sel_t sel_nxt;
  irq_prio_pkg::svc_state_t state_r;
  irq_prio_pkg::svc_state_t state_nxt;
  logic [2:0] hi_id;
  logic [2:0] lo_id;
  logic hi_any;
  logic lo_any;
  logic [5:0] hi_req;
  logic [5:0] lo_req;
  logic can_take;
  logic take_high;
  logic [7:0] status_word;
  logic [7:0] rd_mux;
  logic [7:0] rdata_nxt;
  logic [5:0] prio_nxt;
  logic [5:0] wr_bits;
  logic [2:0] offer_id;
  logic [1:0] state_code;
  logic wr_prio;
  logic rd_prio;
  logic rd_status;
  logic ack_ok;
  logic preempt;
  logic reti_high;
  logic in_idle;
  logic in_low;
  logic in_high;
  logic idle_take;
  logic low_take;
  logic req_any;

  // each select bit maps straight to its source level
  assign o_src_high[irq_prio_pkg::TMR2_BIT] = prio_r[irq_prio_pkg::TMR2_BIT];
  assign o_src_high[irq_prio_pkg::SER0_BIT] = prio_r[irq_prio_pkg::SER0_BIT];
  assign o_src_high[irq_prio_pkg::TMR1_BIT] = prio_r[irq_prio_pkg::TMR1_BIT];
  assign o_src_high[irq_prio_pkg::EXT1_BIT] = prio_r[irq_prio_pkg::EXT1_BIT];
  assign o_src_high[irq_prio_pkg::TMR0_BIT] = prio_r[irq_prio_pkg::TMR0_BIT];
  assign o_src_high[irq_prio_pkg::EXT0_BIT] = prio_r[irq_prio_pkg::EXT0_BIT];

  // split every request into its level; the mask is the select bit itself
  for (genvar g = 0; g < irq_prio_pkg::NUM_SRC; g++) begin : g_src
    logic req_bit;
    logic high_bit;
    assign req_bit = i_irq_req[g];
    assign high_bit = o_src_high[g];
    assign hi_req[g] = req_bit && high_bit;
    assign lo_req[g] = req_bit && !high_bit;
  end

  assign hi_any = |hi_req;
  assign lo_any = |lo_req;

  // fixed order within a level: lowest bit wins, like the usual polling chain
  always_comb begin
    hi_id = irq_prio_pkg::NO_SRC;
    lo_id = irq_prio_pkg::NO_SRC;
    for (int i = irq_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (hi_req[i]) begin
        hi_id = 3'(i);
      end
      if (lo_req[i]) begin
        lo_id = 3'(i);
      end
    end
  end

  // only one nesting level of low under high is tracked, matching two levels
  assign take_high = hi_any;
  assign in_idle = state_r == irq_prio_pkg::ST_IDLE;
  assign in_low = state_r == irq_prio_pkg::ST_LOW;
  assign in_high = state_r == irq_prio_pkg::ST_HIGH;
  assign req_any = hi_any || lo_any;
  assign idle_take = in_idle && req_any;
  assign low_take = in_low && hi_any;
  assign can_take = idle_take || low_take;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      irq_prio_pkg::ST_IDLE: begin
        if (i_ack && can_take) begin
          state_nxt = take_high ? irq_prio_pkg::ST_HIGH : irq_prio_pkg::ST_LOW;
        end
      end
      irq_prio_pkg::ST_LOW: begin
        if (i_ack && can_take) begin
          state_nxt = irq_prio_pkg::ST_HIGH;
        end else if (i_reti) begin
          state_nxt = irq_prio_pkg::ST_IDLE;
        end
      end
      irq_prio_pkg::ST_HIGH: begin
        if (i_reti) begin
          state_nxt = sel_r.valid && !sel_r.high ? irq_prio_pkg::ST_LOW : irq_prio_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = irq_prio_pkg::ST_IDLE;
      end
    endcase
  end

  // register decode
  assign wr_prio = i_wr && (i_addr == irq_prio_pkg::ADDR_PRIO);
  assign rd_prio = i_addr == irq_prio_pkg::ADDR_PRIO;
  assign rd_status = i_addr == irq_prio_pkg::ADDR_STATUS;

  // bits 7:6 of the select register do not exist and read back as zero
  assign wr_bits = i_wdata[5:0];
  assign prio_nxt = wr_prio ? wr_bits : prio_r;
  assign state_code = state_r;
  assign status_word = {state_code, i_irq_req};
  assign rd_mux = rd_prio ? {2'h0, prio_r} :
                  rd_status ? status_word :
                  8'h00;
  assign rdata_nxt = i_rd ? rd_mux : 8'h00;

  // service bookkeeping
  assign ack_ok = i_ack && can_take;
  assign preempt = ack_ok && in_low;
  assign reti_high = i_reti && in_high;
  assign offer_id = take_high ? hi_id : lo_id;

  // remember a low service that was preempted so return resumes it
  always_comb begin
    sel_nxt = sel_r;
    if (preempt) begin
      sel_nxt.valid = 1'b1;
      sel_nxt.high = 1'b0;
    end else if (ack_ok) begin
      sel_nxt.valid = 1'b0;
      sel_nxt.high = take_high;
      sel_nxt.id = offer_id;
    end else if (reti_high) begin
      sel_nxt = '0;
    end
  end

  // every register holds while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      prio_r <= irq_prio_pkg::PRIO_RESET[5:0];
    end else if (i_ce) begin
      prio_r <= prio_nxt;
    end
  end

  // read data lives one cycle, then drops back to zero
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rdata_r <= 8'h00;
    end else if (i_ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // service level
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r <= irq_prio_pkg::ST_IDLE;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // preempted low record
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sel_r <= '0;
    end else if (i_ce) begin
      sel_r <= sel_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_irq_take = can_take;
  assign o_irq_id = offer_id;

endmodule : interrupt_priority_select

// >>> test/core_model.sv
`timescale 1ns/1ps
module core_model(input wire logic i_clk, i_en, i_ret, o_irq_take, output logic o_ack, o_reti);
  // i_en low stalls acceptance, so one model answers fast or late
  always_ff @(posedge i_clk) begin
    o_ack <= i_en && o_irq_take && !o_ack;
    o_reti <= i_ret && !i_en;
  end
endmodule : core_model

// >>> test/prio_chk_props.sv
`timescale 1ns/1ps
module prio_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [5:0] i_irq_req,
  input wire logic o_irq_take,
  input wire logic [2:0] o_irq_id,
  input wire logic [5:0] o_src_high
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic w0 = i_ce && i_wr && i_addr == 4'h0;
  wire logic [5:0] hreq = i_irq_req & o_src_high;
  a_prio_bits: assert property (w0 |=> o_src_high == $past(i_wdata[5:0])) else $error("select bits not taken");
  a_prio_hold: assert property (!w0 |=> $stable(o_src_high)) else $error("select bits moved");
  a_rd_prio: assert property (i_ce && i_rd && i_addr == 4'h0 |=> o_rdata == {2'h0, $past(o_src_high)})
    else $error("select readback wrong");
  a_rd_quiet: assert property (i_ce && !i_rd |=> o_rdata == 8'h00) else $error("read data not zero");
  a_ce_freeze: assert property (!i_ce |=> $stable(o_src_high) && $stable(o_rdata)) else $error("state moved");
  a_id_none: assert property (!(|i_irq_req) |-> o_irq_id == 3'h7) else $error("id without request");
  a_high_first: assert property (o_irq_take && |hreq |-> o_src_high[o_irq_id])
    else $error("high request not first");
  a_low_only: assert property (o_irq_take && !(|hreq) |-> !o_src_high[o_irq_id] && i_irq_req[o_irq_id])
    else $error("low offer wrong");
  c_wr: cover property (w0);
  c_take: cover property (o_irq_take);
  c_none: cover property (o_irq_id == 3'h7);
  c_freeze: cover property (!i_ce && i_wr);
endmodule : prio_chk
bind interrupt_priority_select prio_chk prio_chk_inst(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
  .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_irq_req(i_irq_req),
  .o_irq_take(o_irq_take), .o_irq_id(o_irq_id), .o_src_high(o_src_high));

// >>> test/interrupt_priority_select_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) cmp_count++; if ((a) !== (b)) begin err_total++; $display("Error %0t %h %h", $time, a, b); end
module interrupt_priority_select_bench;
  logic i_clk, i_reset_n, i_ce, i_wr, i_rd, i_en, i_ret, i_ack, i_reti, o_irq_take;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, d;
  logic [5:0] i_irq_req, o_src_high, prio_m;
  logic [2:0] o_irq_id;
  int err_total, cmp_count;
  interrupt_priority_select interrupt_priority_select_inst(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_req(i_irq_req),
    .i_ack(i_ack), .i_reti(i_reti), .o_irq_take(o_irq_take), .o_irq_id(o_irq_id), .o_src_high(o_src_high));
  core_model core_model_inst(.i_clk(i_clk), .i_en(i_en), .i_ret(i_ret), .o_irq_take(o_irq_take),
    .o_ack(i_ack), .o_reti(i_reti));
  // expected offer: high level first, lowest bit within a level, 7 when idle
  function automatic logic [2:0] exp_id(input logic [5:0] req, input logic [5:0] high);
    logic [5:0] pick;
    exp_id = 3'h7;
    pick = (|(req & high)) ? (req & high) : (req & ~high);
    for (int i = 5; i >= 0; i--) begin
      if (pick[i]) exp_id = 3'(i);
    end
  endfunction : exp_id
  task automatic bus(input logic [3:0] a, input logic [7:0] dv, input logic w, input logic rnd);
    logic [7:0] r;
    r = 8'($urandom);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= dv;
    if (rnd) {i_irq_req, i_en, i_ret} <= r;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    #1;
  endtask : bus
  // one ack (ret low) or one return (ret high) from the core model
  task automatic core_pulse(input logic ret);
    @(posedge i_clk);
    i_en <= !ret;
    i_ret <= ret;
    @(posedge i_clk);
    i_en <= 1'b0;
    i_ret <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask : core_pulse
  task test_done;
    $display("%0d checks %0d errors", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    #20000 err_total++;
    test_done;
  end
  initial begin
    {i_reset_n, i_ce, i_wr, i_rd, i_en, i_ret, i_addr, i_wdata, i_irq_req} = '0;
    prio_m = 6'h00;
    void'($urandom(32'h2BB3));
    repeat (6) @(posedge i_clk);
    {i_reset_n, i_ce} <= 2'h3;
    repeat (20) begin
      d = 8'($urandom);
      bus(irq_prio_pkg::ADDR_PRIO, d, 1'b1, 1'b1);
      prio_m = d[5:0];
      `CHK(o_src_high, prio_m)
      `CHK(o_irq_id, exp_id(i_irq_req, prio_m))
      bus(irq_prio_pkg::ADDR_PRIO, 8'h00, 1'b0, 1'b1);
      `CHK(o_rdata, {2'h0, prio_m})
      `CHK(o_irq_id, exp_id(i_irq_req, prio_m))
      bus(4'h5, 8'($urandom), 1'b1, 1'b1);
      `CHK(o_src_high, prio_m)
      bus(4'hF, 8'h00, 1'b0, 1'b1);
      `CHK(o_rdata, 8'h00)
    end
    $display("test random done");
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    i_en <= 1'b0;
    i_ret <= 1'b0;
    i_irq_req <= 6'h00;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    prio_m = irq_prio_pkg::PRIO_RESET[5:0];
    #1;
    `CHK(o_src_high, prio_m)
    `CHK(o_rdata, 8'h00)
    $display("test reset done");
    bus(irq_prio_pkg::ADDR_PRIO, 8'hE0, 1'b1, 1'b0);
    prio_m = 6'h20;
    `CHK(o_src_high, prio_m)
    @(posedge i_clk);
    i_irq_req <= 6'h01;
    #1;
    `CHK(o_irq_take, 1'b1)
    `CHK(o_irq_id, 3'h0)
    core_pulse(1'b0);
    `CHK(o_irq_take, 1'b0)
    bus(irq_prio_pkg::ADDR_STATUS, 8'h00, 1'b0, 1'b0);
    `CHK(o_rdata, 8'h41)
    @(posedge i_clk);
    i_irq_req <= 6'h21;
    #1;
    `CHK(o_irq_take, 1'b1)
    `CHK(o_irq_id, 3'h5)
    core_pulse(1'b0);
    `CHK(o_irq_take, 1'b0)
    bus(irq_prio_pkg::ADDR_STATUS, 8'h00, 1'b0, 1'b0);
    `CHK(o_rdata, 8'hE1)
    @(posedge i_clk);
    i_irq_req <= 6'h01;
    core_pulse(1'b1);
    `CHK(o_irq_take, 1'b0)
    bus(irq_prio_pkg::ADDR_STATUS, 8'h00, 1'b0, 1'b0);
    `CHK(o_rdata, 8'h41)
    core_pulse(1'b1);
    `CHK(o_irq_take, 1'b1)
    bus(irq_prio_pkg::ADDR_STATUS, 8'h00, 1'b0, 1'b0);
    `CHK(o_rdata, 8'h01)
    @(posedge i_clk);
    i_ce <= 1'b0;
    bus(irq_prio_pkg::ADDR_PRIO, 8'h3F, 1'b1, 1'b0);
    `CHK(o_src_high, prio_m)
    @(posedge i_clk);
    i_ce <= 1'b1;
    $display("test priority done");
    test_done;
  end
endmodule : interrupt_priority_select_bench
